// ===== include/eep_pkg.sv
// Shared constants and types for the debug event pin link
package eep_pkg;
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned TEST_CLK_PERIOD_NS = 100;
	localparam int unsigned PULSE_MAX_NS = 10000;
	localparam int unsigned PULSE_MIN_CYC = (TEST_CLK_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS + 1;
	localparam int unsigned PULSE_MAX_CYC = (PULSE_MAX_NS * 1000) / CLK_PERIOD_PS - 1;
	localparam int unsigned PULSE_CYC = PULSE_MIN_CYC * 2;
	localparam int unsigned PULSE_CNT_W = 12;
	localparam logic [PULSE_CNT_W-1:0] PULSE_CNT_RESET = 12'h000;
	localparam int unsigned PIN_COUNT = 2;
	localparam int unsigned PIN_HALTED_IDX = 0;
	localparam int unsigned PIN_CARRY_IDX = 1;
	localparam logic PIN_VAL_RESET = 1'b1;
	localparam logic PIN_OE_N_RESET = 1'b1;
	localparam logic HALT_RESET = 1'b0;
	localparam logic ARMED_RESET = 1'b1;
	localparam logic PULSE_RESET = 1'b0;

	typedef enum logic [1:0] {
		EEP_MODE_IDLE,
		EEP_MODE_SIGNAL,
		EEP_MODE_COUNT
	} eep_mode_t;
endpackage

// ===== include/eep_if.sv
// Interface joining device event pins and board pulse logic
`timescale 1ns/1ps
interface eep_if;
	// Device pin drives, enables active low
	logic [1:0] pinOut;
	logic [1:0] pinOeN;
	// Resolved bused output line level (testbench resolves with pull-up)
	logic [1:0] pinIn;
	// Pulse logic drive onto shared input line
	logic [1:0] inLineOut;
	logic [1:0] inLineOeN;
	// Resolved shared input line level
	logic [1:0] inLineLevel;

	modport device (output pinOut, output pinOeN, input pinIn, input inLineLevel);
	modport board (input pinIn, output inLineOut, output inLineOeN, input inLineLevel);
endinterface

// ===== logic/eep_device.sv
// Debug event pin logic of the processor end
`timescale 1ns/1ps
// Notes on behaviour
// - Idle pins float, driving nothing
// - Signal-event mode drives pins low only
// - External sources drive lines open-collector only
// - External-count mode drives pins push-pull
// - External sources stay inactive during count
// - Enabled halt when event line seen low
// - Pulse logic pulses input on output low
// - Pulse longer than test clock, under 10us
// - Count mode: pin b carry, pin a halted
// - Input line held high during count run
// - Count gate stops pulse logic driving low
// - Board edge splits input and output lines
// ------------------------------------------------------------
// Overview
// ------------------------------------------------------------
// Pins share lines with other devices through pull-ups; only count
// mode may drive high, so software must keep one pusher per line.
// Halt follows the board's input line, never our own output pin.
module eep_device import eep_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,

	// Link
	eep_if.device link,

	// Software control
	input wire eep_mode_t mode,
	input wire logic haltEnable,
	input wire logic [1:0] eventAssert,

	// Core status
	input wire logic counterCarry,
	input wire logic coreHalted,

	// Halt request to core
	output logic haltRequest_q
);
	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	// Unpacked so each pin is written by its own processes
	logic driveVal_q [PIN_COUNT];
	logic driveVal_d [PIN_COUNT];
	logic oeN_q [PIN_COUNT];
	logic oeN_d [PIN_COUNT];
	logic haltAllowed;
	logic lineLow;
	logic haltRequest_d;

	// ------------------------------------------------------------
	// Mode decoding
	// ------------------------------------------------------------
	// Level a pin shows when enabled; only count mode drives it high
	function automatic logic pinValue(
		input eep_mode_t m,
		input int unsigned idx,
		input logic carry,
		input logic halted
	);
		logic val;
		val = PIN_VAL_RESET;
		unique case (m)
			EEP_MODE_IDLE: begin
				val = PIN_VAL_RESET;
			end
			EEP_MODE_SIGNAL: begin
				val = 1'b0;
			end
			EEP_MODE_COUNT: begin
				if (idx == PIN_CARRY_IDX) begin
					val = carry;
				end else begin
					val = halted;
				end
			end
			// Spare code of the 2-bit mode; treated as idle
			default: begin
				val = PIN_VAL_RESET;
			end
		endcase
		return val;
	endfunction

	// Enable for one pin, low while driving
	function automatic logic pinEnableN(
		input eep_mode_t m,
		input logic wantLow
	);
		logic oeN;
		oeN = PIN_OE_N_RESET;
		unique case (m)
			EEP_MODE_IDLE: begin
				oeN = PIN_OE_N_RESET;
			end
			EEP_MODE_SIGNAL: begin
				// Released rather than driven high: open-collector style
				oeN = !wantLow;
			end
			EEP_MODE_COUNT: begin
				oeN = 1'b0;
			end
			default: begin
				oeN = PIN_OE_N_RESET;
			end
		endcase
		return oeN;
	endfunction

	// Any input line held low by anyone is a stop request
	function automatic logic lineSeenLow(input logic [1:0] level);
		logic low;
		low = 1'b0;
		for (int unsigned i = 0; i < PIN_COUNT; i++) begin
			if (!level[i]) begin
				low = 1'b1;
			end
		end
		return low;
	endfunction

	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------
	// Value and enable move together, one cycle after the controls
	genvar p;
	generate
		for (p = 0; p < PIN_COUNT; p++) begin : gPin
			always_comb begin
				driveVal_d[p] = pinValue(mode, p, counterCarry, coreHalted);
			end

			always_comb begin
				oeN_d[p] = pinEnableN(mode, eventAssert[p]);
			end

			// Drive value
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					driveVal_q[p] <= PIN_VAL_RESET;
				end else begin
					driveVal_q[p] <= driveVal_d[p];
				end
			end

			// Drive enable, released out of reset
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					oeN_q[p] <= PIN_OE_N_RESET;
				end else begin
					oeN_q[p] <= oeN_d[p];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Link drive
	// ------------------------------------------------------------
	// Open-collector use shows as value low with the enable toggling
	assign link.pinOut = {driveVal_q[PIN_CARRY_IDX], driveVal_q[PIN_HALTED_IDX]};
	assign link.pinOeN = {oeN_q[PIN_CARRY_IDX], oeN_q[PIN_HALTED_IDX]};

	// ------------------------------------------------------------
	// Halt on shared event
	// ------------------------------------------------------------
	// Only in idle and signal modes; in count mode our own push-pull drive would self-halt
	always_comb begin
		haltAllowed = 1'b0;
		unique case (mode)
			EEP_MODE_IDLE: begin
				// Floating pins do not stop others from halting us
				haltAllowed = haltEnable;
			end
			EEP_MODE_SIGNAL: begin
				haltAllowed = haltEnable;
			end
			EEP_MODE_COUNT: begin
				haltAllowed = 1'b0;
			end
			default: begin
				haltAllowed = 1'b0;
			end
		endcase
	end

	always_comb begin
		lineLow = lineSeenLow(link.inLineLevel);
	end

	always_comb begin
		haltRequest_d = haltAllowed && lineLow;
	end

	// Registered, so a glitch on the input line cannot reach the core
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			haltRequest_q <= HALT_RESET;
		end else begin
			haltRequest_q <= haltRequest_d;
		end
	end
endmodule

// ===== logic/eep_board.sv
// Board pulse logic that turns a bused low into a bounded pulse
`timescale 1ns/1ps
module eep_board import eep_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Link
	eep_if.board link,
	// External count enable, active high
	input wire logic external_count_gate,
	// Status
	output logic [1:0] pulseActive_q
);
	// One process per line, so each line owns its own flop
	logic pulseLine_q [PIN_COUNT];

	genvar g;
	generate
		for (g = 0; g < PIN_COUNT; g++) begin : gLine
			logic [PULSE_CNT_W-1:0] cnt_q;
			logic armed_q;

			// Separate in and out nets keep the drivers from latching
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					cnt_q <= PULSE_CNT_RESET;
					armed_q <= ARMED_RESET;
					pulseLine_q[g] <= PULSE_RESET;
				end else if (external_count_gate) begin
					cnt_q <= PULSE_CNT_RESET;
					armed_q <= 1'b0;
					pulseLine_q[g] <= 1'b0;
				end else if (pulseLine_q[g]) begin
					// Width fixed between one test clock and 10 us
					if (cnt_q == PULSE_CNT_W'(PULSE_CYC - 1)) begin
						pulseLine_q[g] <= 1'b0;
						cnt_q <= PULSE_CNT_RESET;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end else if (armed_q && !link.pinIn[g]) begin
					pulseLine_q[g] <= 1'b1;
					armed_q <= 1'b0;
				end else if (link.pinIn[g]) begin
					armed_q <= 1'b1;
				end
			end
		end
	endgenerate

	assign pulseActive_q = {pulseLine_q[1], pulseLine_q[0]};
	assign link.inLineOut = 2'h0;
	assign link.inLineOeN = ~pulseActive_q;
endmodule

// ===== tb/eep_chk.sv
// Link checker for the event pins and pulse logic
`timescale 1ns/1ps
module eep_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Link signals
	input wire logic [1:0] pinOut,
	input wire logic [1:0] pinOeN,
	input wire logic [1:0] pinIn,
	input wire logic [1:0] inLineOeN
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_low_only: assert property (^pinOeN |-> !(pinOut & ~pinOeN)) else $error("drive");
	a_pulse_start: assert property ($fell(pinIn[0]) && |pinOeN |=> !inLineOeN[0])
		else $error("start");
	a_start_b: assert property ($fell(pinIn[1]) && |pinOeN |=> !inLineOeN[1])
		else $error("start b");
	a_width_b: assert property ($fell(inLineOeN[1]) |->
		##20 !inLineOeN[1] ##[1:1000] inLineOeN[1]) else $error("width b");
	a_pulse_width: assert property ($fell(inLineOeN[0]) |->
		##20 !inLineOeN[0] ##[1:1000] inLineOeN[0]) else $error("width");
	a_count_quiet: assert property (!(pinOeN | $past(pinOeN)) |-> &inLineOeN)
		else $error("quiet");
endmodule

// ===== tb/test_emulation_event_pin_logic.sv
// Testbench for the event pin link
`timescale 1ns/1ps
module test_emulation_event_pin_logic import eep_pkg::*;;
	logic clk = 1'h0, arst_n = 1'h0, hEn = 1'h0, gate = 1'h0, cy = 1'h0, hd = 1'h0, hq;
	logic [1:0] ev = 2'h0, act;
	eep_mode_t mode = EEP_MODE_IDLE;
	int errors = 0, checks = 0, n;
	eep_if lnk();
	// Pull-ups on both lines, so a released line reads high
	assign lnk.pinIn = lnk.pinOeN | lnk.pinOut, lnk.inLineLevel = lnk.inLineOeN | lnk.inLineOut;
	eep_device i_eep_device (.clk, .arst_n, .link(lnk), .mode, .haltEnable(hEn), .eventAssert(ev),
		.counterCarry(cy), .coreHalted(hd), .haltRequest_q(hq));
	eep_board i_eep_board (.clk, .arst_n, .link(lnk), .external_count_gate(gate),
		.pulseActive_q(act));
	eep_chk i_eep_chk (.clk, .arst_n, .pinOut(lnk.pinOut), .pinOeN(lnk.pinOeN), .pinIn(lnk.pinIn),
		.inLineOeN(lnk.inLineOeN));
	initial forever #2.5 clk = ~clk;
	task cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task ck(input logic [11:0] s, e);
		checks++;
		errors += (s !== e);
		if (s !== e) $display("ERROR %0t %h %h", $time, s, e);
	endtask
	task complete_run;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task t_signal;
		mode = EEP_MODE_SIGNAL;
		// Moving to line b releases line a in the same step
		for (int b = 0; b < 2; b++) begin
			{hEn, ev} = {1'h1, 2'h1 << b};
			cyc(4);
			ck({lnk.pinOeN ^ ev, hq}, 3'h7);
			for (n = 0; act[b] === 1'h1 && n < 3000; n++) cyc(1);
			cyc(20);
			ck({n > PULSE_MIN_CYC && n < PULSE_MAX_CYC, lnk.inLineLevel}, 3'h7);
		end
		$display("t_signal done");
	endtask
	task t_count;
		mode = EEP_MODE_COUNT;
		{gate, cy} = 2'h3;
		cyc(3);
		ck({lnk.pinIn, lnk.inLineLevel, hq}, 5'h16);
		{cy, hd} = 2'h1;
		cyc(2);
		ck({lnk.pinIn, lnk.inLineLevel, hq}, 5'h0e);
		mode = EEP_MODE_IDLE;
		gate = 1'h0;
		cyc(3);
		ck({lnk.pinOeN, lnk.inLineLevel}, 4'hf);
		$display("t_count done");
	endtask
	initial begin
		cyc(3);
		arst_n = 1'h1;
		ck(lnk.pinOeN, 2'h3);
		$display("t_reset done");
		t_signal;
		t_count;
		complete_run;
	end
	initial #20000 begin
		errors++;
		complete_run;
	end
endmodule
